// >>> core/cgpr_bank.sv
`default_nettype none
// One bank of sixteen 32-bit registers with 64-bit pair read and 32/64-bit write
module cgpr_bank #(
  parameter logic [31:0] RESET_VAL = 32'h0000_0000
) (
  input  wire logic                 clk_sys_in,
  input  wire logic                 rstn_in,
  input  wire cgpr_pkg::cgpr_wr_t   wr_in,
  input  wire logic [3:0]           rd_idx_in,
  input  wire logic                 rd_short_in,
  output logic [63:0]               rd_data_out,
  output logic [15:0][31:0]         regs_out
);
  logic [15:0][31:0] regs;
  wire  [3:0]        wr_idx  = wr_in.short_enc ? cgpr_pkg::IDX_IMPLICIT : wr_in.idx;
  wire  [3:0]        rd_idx  = rd_short_in ? cgpr_pkg::IDX_IMPLICIT : rd_idx_in;
  wire  [3:0]        rd_even = {rd_idx[3:1], 1'b0};
  wire  [3:0]        wr_even = {wr_idx[3:1], 1'b0};

  // ==========================================================
  // Storage
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (int i = 0; i < 16; i++)
      begin
        regs[i] <= RESET_VAL;
      end
    end
    else if (wr_in.en)
    begin
      if (wr_in.pair)
      begin
        regs[wr_even]        <= wr_in.data[31:0];
        regs[wr_even | 4'h1] <= wr_in.data[63:32];
      end
      else
      begin
        regs[wr_idx] <= wr_in.data[31:0];
      end
    end
  end

  // Reads always give the pair view: odd word high, even word low
  assign rd_data_out = {regs[rd_even | 4'h1], regs[rd_even]};
  assign regs_out    = regs;
endmodule
`default_nettype wire

// >>> core/cgpr_file.sv
`default_nettype none
module cgpr_file #(
  parameter logic [31:0] DATA_RESET = 32'h0000_0000,
  parameter logic [31:0] ADDR_RESET = 32'h0000_0000,
  parameter logic [31:0] CORE_SPECIAL_REGISTER_RESET = 32'h0000_0000
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rstn_in,
  // Pipeline GPR write ports
  input  wire cgpr_pkg::cgpr_wr_t      data_wr_in,
  input  wire cgpr_pkg::cgpr_wr_t      addr_wr_in,
  // Call/trap link: writes return address into A11 with priority
  input  wire logic                    link_en_in,
  input  wire logic [31:0]             link_addr_in,
  // Pipeline GPR read ports
  input  wire logic [3:0]              data_rd_idx_in,
  input  wire logic                    data_rd_short_in,
  input  wire logic [3:0]              addr_rd_idx_in,
  input  wire logic                    addr_rd_short_in,
  output logic [63:0]                  data_rd_out,
  output logic [63:0]                  addr_rd_out,
  output logic [31:0]                  stack_ptr_out,
  output logic [31:0]                  return_addr_out,
  // Context save/restore group select: 0 lower, 1 upper
  input  wire logic                    ctx_upper_in,
  output logic [15:0]                  ctx_data_mask_out,
  output logic [15:0]                  ctx_addr_mask_out,
  // Core register space access
  input  wire cgpr_pkg::cgpr_core_special_register_wr_t core_special_register_wr_in,
  input  wire logic [15:0]             core_special_register_rd_addr_in,
  output logic [31:0]                  core_special_register_rd_data_out,
  output logic                         core_special_register_wr_refused_out,
  // Initialisation state end, from system logic
  input  wire logic                    init_done_in
);
  // ==========================================================
  // Init phase lock
  logic init_sync1;
  logic init_sync2;
  logic init_phase_lock;

  // Synchronised; once operational the lock stays set until reset
  always_ff @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      init_sync1      <= 1'b0;
      init_sync2      <= 1'b0;
      init_phase_lock <= 1'b0;
    end
    else
    begin
      init_sync1      <= init_done_in;
      init_sync2      <= init_sync1;
      init_phase_lock <= init_phase_lock | init_sync2;
    end
  end

  // ==========================================================
  // Register banks
  logic [15:0][31:0] data_regs;
  logic [15:0][31:0] addr_regs;
  logic [63:0]       data_pair;
  logic [63:0]       addr_pair;
  cgpr_pkg::cgpr_wr_t data_wr_eff;
  cgpr_pkg::cgpr_wr_t addr_wr_eff;

  wire [15:0] core_special_register_d_off = core_special_register_wr_in.addr - cgpr_pkg::DATA_BASE;
  wire [15:0] core_special_register_a_off = core_special_register_wr_in.addr - cgpr_pkg::ADDR_BASE;
  wire        core_special_register_hit_d = core_special_register_wr_in.en && (core_special_register_wr_in.addr[15:6] == cgpr_pkg::DATA_BASE[15:6])
                           && (core_special_register_wr_in.addr[1:0] == 2'b00);
  wire        core_special_register_hit_a = core_special_register_wr_in.en && (core_special_register_wr_in.addr[15:6] == cgpr_pkg::ADDR_BASE[15:6])
                           && (core_special_register_wr_in.addr[1:0] == 2'b00);

  // Pipeline write wins over a space write to the same bank in one cycle
  always_comb
  begin
    data_wr_eff = data_wr_in;
    if (!data_wr_in.en && core_special_register_hit_d)
    begin
      data_wr_eff = '{en: 1'b1, short_enc: 1'b0, pair: 1'b0, idx: core_special_register_d_off[5:2],
                      data: {32'h0000_0000, core_special_register_wr_in.data}};
    end
  end

  always_comb
  begin
    addr_wr_eff = addr_wr_in;
    if (link_en_in)
    begin
      addr_wr_eff = '{en: 1'b1, short_enc: 1'b0, pair: 1'b0, idx: cgpr_pkg::IDX_RA,
                      data: {32'h0000_0000, link_addr_in}};
    end
    else if (!addr_wr_in.en && core_special_register_hit_a)
    begin
      addr_wr_eff = '{en: 1'b1, short_enc: 1'b0, pair: 1'b0, idx: core_special_register_a_off[5:2],
                      data: {32'h0000_0000, core_special_register_wr_in.data}};
    end
  end

  // Float operands use the data bank; there is no separate float file
  cgpr_bank #(.RESET_VAL(DATA_RESET)) u_data_bank (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .wr_in      (data_wr_eff),
    .rd_idx_in  (data_rd_idx_in),
    .rd_short_in(data_rd_short_in),
    .rd_data_out(data_pair),
    .regs_out   (data_regs)
  );

  cgpr_bank #(.RESET_VAL(ADDR_RESET)) u_addr_bank (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .wr_in      (addr_wr_eff),
    .rd_idx_in  (addr_rd_idx_in),
    .rd_short_in(addr_rd_short_in),
    .rd_data_out(addr_pair),
    .regs_out   (addr_regs)
  );

  assign data_rd_out     = data_pair;
  assign addr_rd_out     = addr_pair;
  assign stack_ptr_out   = addr_regs[cgpr_pkg::IDX_SP];
  assign return_addr_out = addr_regs[cgpr_pkg::IDX_RA];

  // ==========================================================
  // Context groups; globals never appear in either mask
  assign ctx_data_mask_out = ctx_upper_in ? cgpr_pkg::UPPER_D_MASK
                                          : cgpr_pkg::LOWER_D_MASK;
  assign ctx_addr_mask_out = (ctx_upper_in ? cgpr_pkg::UPPER_A_MASK : cgpr_pkg::LOWER_A_MASK)
                             & ~cgpr_pkg::GLOBAL_A_MASK;

  // ==========================================================
  // Protected special registers
  localparam logic [cgpr_pkg::NUM_LOCKED-1:0][15:0] LOCKED_ADDR = {
    cgpr_pkg::CORE_SPECIAL_REGISTER_SYS_MEM, cgpr_pkg::CORE_SPECIAL_REGISTER_PHYS_MEM, cgpr_pkg::CORE_SPECIAL_REGISTER_MEM_INT,
    cgpr_pkg::CORE_SPECIAL_REGISTER_COMPATIBILITY_CONFIG, cgpr_pkg::CORE_SPECIAL_REGISTER_BUS_MEM, cgpr_pkg::CORE_SPECIAL_REGISTER_INT_SP,
    cgpr_pkg::CORE_SPECIAL_REGISTER_INT_VEC, cgpr_pkg::CORE_SPECIAL_REGISTER_TRAP_VEC};

  logic [cgpr_pkg::NUM_LOCKED-1:0][31:0] locked_regs;
  logic [cgpr_pkg::NUM_LOCKED-1:0]       wr_hit;
  logic [cgpr_pkg::NUM_LOCKED-1:0]       rd_hit;

  genvar g;
  generate
    for (g = 0; g < cgpr_pkg::NUM_LOCKED; g++)
    begin : g_lock
      assign wr_hit[g] = core_special_register_wr_in.en && (core_special_register_wr_in.addr == LOCKED_ADDR[g]);
      assign rd_hit[g] = (core_special_register_rd_addr_in == LOCKED_ADDR[g]);
      always_ff @(posedge clk_sys_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          locked_regs[g] <= CORE_SPECIAL_REGISTER_RESET;
        end
        else if (wr_hit[g] && !init_phase_lock)
        begin
          locked_regs[g] <= core_special_register_wr_in.data;
        end
      end
    end
  endgenerate

  // The lock gates writes only; reads behave the same in both states
  wire        any_wr_hit  = |wr_hit;
  assign core_special_register_wr_refused_out = any_wr_hit && init_phase_lock;

  logic [31:0] locked_rd;
  always_comb
  begin
    locked_rd = 32'h0000_0000;
    for (int i = 0; i < cgpr_pkg::NUM_LOCKED; i++)
    begin
      if (rd_hit[i])
      begin
        locked_rd = locked_regs[i];
      end
    end
  end

  wire [15:0] rd_d_off  = core_special_register_rd_addr_in - cgpr_pkg::DATA_BASE;
  wire [15:0] rd_a_off  = core_special_register_rd_addr_in - cgpr_pkg::ADDR_BASE;
  wire        rd_is_d   = (core_special_register_rd_addr_in[15:6] == cgpr_pkg::DATA_BASE[15:6]);
  wire        rd_is_a   = (core_special_register_rd_addr_in[15:6] == cgpr_pkg::ADDR_BASE[15:6]);
  assign core_special_register_rd_data_out = rd_is_d ? data_regs[rd_d_off[5:2]] :
                            rd_is_a ? addr_regs[rd_a_off[5:2]] : locked_rd;

  // ==========================================================
  // Checks
  a_lock_blocks_wr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (init_phase_lock && wr_hit[2]) |=> $stable(locked_regs[2]))
    else $error("protected register changed after init");
  a_init_allows_wr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!init_phase_lock && wr_hit[0]) |=> locked_regs[0] == $past(core_special_register_wr_in.data))
    else $error("init-state write lost");
  a_lock_sticky: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    init_phase_lock |=> init_phase_lock)
    else $error("lock dropped");
  a_link_to_ra: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    link_en_in |=> return_addr_out == $past(link_addr_in))
    else $error("return address not captured");
  a_sp_tracks_a10: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (addr_wr_in.en && !addr_wr_in.pair && !addr_wr_in.short_enc && !link_en_in
     && addr_wr_in.idx == 4'ha) |=> stack_ptr_out == $past(addr_wr_in.data[31:0]))
    else $error("stack pointer not updated");
  a_pair_write: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (data_wr_in.en && data_wr_in.pair && !data_wr_in.short_enc && data_wr_in.idx == 4'h8)
    |=> {data_regs[9], data_regs[8]} == $past(data_wr_in.data))
    else $error("extended pair order wrong");
  a_short_d15: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (data_wr_in.en && data_wr_in.short_enc && !data_wr_in.pair)
    |=> data_regs[15] == $past(data_wr_in.data[31:0]))
    else $error("short write missed register 15");
  a_global_excluded: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (ctx_addr_mask_out & cgpr_pkg::GLOBAL_A_MASK) == 16'h0000)
    else $error("global register in context");
  a_refuse_flag: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    core_special_register_wr_refused_out |-> init_phase_lock && any_wr_hit)
    else $error("refusal outside lock");
  a_addr_pair_wr: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (addr_wr_in.en && addr_wr_in.pair && !addr_wr_in.short_enc && !link_en_in
     && addr_wr_in.idx == 4'h2)
    |=> {addr_regs[3], addr_regs[2]} == $past(addr_wr_in.data))
    else $error("address pair order wrong");
  a_short_a15: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (addr_wr_in.en && addr_wr_in.short_enc && !addr_wr_in.pair && !link_en_in)
    |=> addr_regs[15] == $past(addr_wr_in.data[31:0]))
    else $error("short write missed address register 15");
  a_space_wr_data: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!data_wr_in.en && core_special_register_hit_d)
    |=> data_regs[$past(core_special_register_d_off[5:2])] == $past(core_special_register_wr_in.data))
    else $error("space write to data register lost");
  a_ctx_lower: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !ctx_upper_in |-> (ctx_data_mask_out == cgpr_pkg::LOWER_D_MASK
                       && ctx_addr_mask_out == cgpr_pkg::LOWER_A_MASK))
    else $error("lower context group wrong");
  a_ctx_upper: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    ctx_upper_in |-> (ctx_data_mask_out == cgpr_pkg::UPPER_D_MASK
                      && ctx_addr_mask_out == cgpr_pkg::UPPER_A_MASK))
    else $error("upper context group wrong");
  a_locked_read: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    rd_hit[1] |-> core_special_register_rd_data_out == locked_regs[1])
    else $error("protected register read differs");
  a_refuse_locked: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (init_phase_lock && any_wr_hit) |-> core_special_register_wr_refused_out)
    else $error("locked write not flagged");
  a_init_stays: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (!init_sync2 && !init_phase_lock) |=> !init_phase_lock)
    else $error("lock set without system request");
  c_refused_wr: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    core_special_register_wr_refused_out);
  c_init_wr: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    !init_phase_lock && any_wr_hit);
  c_link: cover property (@(posedge clk_sys_in) disable iff (!rstn_in) link_en_in);
  c_pair: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
    addr_wr_in.en && addr_wr_in.pair);
endmodule
`default_nettype wire

// >>> core/cgpr_pkg.sv
`default_nettype none
package cgpr_pkg;
  localparam int unsigned NUM_REGS      = 16;
  localparam int unsigned NUM_PAIRS     = 8;
  localparam logic [15:0] DATA_BASE     = 16'hff00;
  localparam logic [15:0] ADDR_BASE     = 16'hff80;
  localparam logic [3:0]  IDX_SP        = 4'ha;
  localparam logic [3:0]  IDX_RA        = 4'hb;
  localparam logic [3:0]  IDX_IMPLICIT  = 4'hf;
  localparam logic [15:0] GLOBAL_A_MASK = 16'h0303;
  localparam logic [15:0] LOWER_A_MASK  = 16'h00fc;
  localparam logic [15:0] LOWER_D_MASK  = 16'h00ff;
  localparam logic [15:0] UPPER_A_MASK  = 16'hfc00;
  localparam logic [15:0] UPPER_D_MASK  = 16'hff00;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_TRAP_VEC = 16'hfe24;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_INT_VEC  = 16'hfe20;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_INT_SP   = 16'hfe28;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_BUS_MEM  = 16'h9004;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_COMPATIBILITY_CONFIG   = 16'h9400;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_MEM_INT  = 16'h9044;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_PHYS_MEM = 16'h8100;
  localparam logic [15:0] CORE_SPECIAL_REGISTER_SYS_MEM  = 16'h900c;
  localparam int unsigned NUM_LOCKED    = 8;

  typedef struct packed {
    logic        en;
    logic        short_enc;
    logic        pair;
    logic [3:0]  idx;
    logic [63:0] data;
  } cgpr_wr_t;

  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [31:0] data;
  } cgpr_core_special_register_wr_t;
endpackage
`default_nettype wire

// >>> sim/cgpr_sys_model.sv
`default_nettype none
// ==========================================
// System init control, far side of the lock
module cgpr_sys_model #(
  parameter int unsigned DELAY = 3
) (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic end_req_in,
  output logic      init_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  // Level stays up until reset, so the core only ever sees one transition
  always_ff @(posedge clk_sys_in or negedge rstn_in)
    if (!rstn_in)
    begin
      cnt           <= 0;
      init_done_out <= 1'b0;
    end
    else if ((end_req_in || cnt != 0) && !init_done_out)
    begin
      cnt <= cnt + 1;
      if (cnt == DELAY)
        init_done_out <= 1'b1;
    end
endmodule
`default_nettype wire

// >>> sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals and model state
  logic                    clk_sys_in, rstn_in, link_en_in, ctx_upper_in;
  logic                    end_req, init_done, data_rd_short_in, addr_rd_short_in;
  logic                    core_special_register_wr_refused_out;
  logic [3:0]              data_rd_idx_in, addr_rd_idx_in;
  logic [31:0]             link_addr_in, stack_ptr_out, return_addr_out, core_special_register_rd_data_out;
  logic [63:0]             data_rd_out, addr_rd_out;
  logic [15:0]             ctx_data_mask_out, ctx_addr_mask_out, core_special_register_rd_addr_in;
  cgpr_pkg::cgpr_wr_t      data_wr_in, addr_wr_in;
  cgpr_pkg::cgpr_core_special_register_wr_t core_special_register_wr_in;
  logic [31:0]             mm [2][16];
  logic [31:0]             pv [8];
  logic [15:0]             prot [8];
  logic [31:0]             r;
  int                      miscompares, compares, seed, i;

  cgpr_file u_dut (.clk_sys_in, .rstn_in, .data_wr_in, .addr_wr_in, .link_en_in,
    .link_addr_in, .data_rd_idx_in, .data_rd_short_in, .addr_rd_idx_in, .addr_rd_short_in,
    .data_rd_out, .addr_rd_out, .stack_ptr_out, .return_addr_out, .ctx_upper_in,
    .ctx_data_mask_out, .ctx_addr_mask_out, .core_special_register_wr_in, .core_special_register_rd_addr_in,
    .core_special_register_rd_data_out, .core_special_register_wr_refused_out, .init_done_in(init_done));
  cgpr_sys_model u_sys (.clk_sys_in, .rstn_in, .end_req_in(end_req),
    .init_done_out(init_done));

  // ==========================================
  // Tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register write; the model follows the short and pair forms
  task automatic gw(input int a, input logic s, input logic p, input logic [3:0] i,
                    input logic [63:0] v);
    logic [3:0] k;
    k = s ? 4'hf : i;
    @(posedge clk_sys_in);
    if (a == 1)
      addr_wr_in <= '{1'b1, s, p, i, v};
    else
      data_wr_in <= '{1'b1, s, p, i, v};
    @(posedge clk_sys_in);
    addr_wr_in.en <= 1'b0;
    data_wr_in.en <= 1'b0;
    if (p)
    begin
      mm[a][k & 4'he] = v[31:0];
      mm[a][k | 4'h1] = v[63:32];
    end
    else
      mm[a][k] = v[31:0];
  endtask

  task automatic gr(input int a, input logic s, input logic [3:0] i);
    logic [3:0] k;
    k = s ? 4'hf : i;
    @(posedge clk_sys_in);
    data_rd_idx_in   <= i;
    addr_rd_idx_in   <= i;
    data_rd_short_in <= s;
    addr_rd_short_in <= s;
    #1;
    chk(a == 1 ? addr_rd_out : data_rd_out, {mm[a][k | 4'h1], mm[a][k & 4'he]});
  endtask

  task automatic cw(input logic [15:0] ad, input logic [31:0] v, input logic rf);
    @(posedge clk_sys_in);
    core_special_register_wr_in <= '{1'b1, ad, v};
    #1;
    chk(core_special_register_wr_refused_out, rf);
    @(posedge clk_sys_in);
    core_special_register_wr_in.en <= 1'b0;
  endtask

  task automatic cr(input logic [15:0] ad, input logic [31:0] e);
    @(posedge clk_sys_in);
    core_special_register_rd_addr_in <= ad;
    #1;
    chk(core_special_register_rd_data_out, e);
  endtask

  // ==========================================
  // Clock, watchdog and main sequence
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  initial
  begin
    #200us;
    miscompares++;
    results();
  end

  initial
  begin
    seed = 98202;
    {rstn_in, link_en_in, ctx_upper_in, end_req, data_rd_short_in, addr_rd_short_in} = '0;
    {data_rd_idx_in, addr_rd_idx_in, link_addr_in, core_special_register_rd_addr_in} = '0;
    data_wr_in = '0;
    addr_wr_in = '0;
    core_special_register_wr_in = '0;
    prot = '{cgpr_pkg::CORE_SPECIAL_REGISTER_TRAP_VEC, cgpr_pkg::CORE_SPECIAL_REGISTER_INT_VEC, cgpr_pkg::CORE_SPECIAL_REGISTER_INT_SP,
             cgpr_pkg::CORE_SPECIAL_REGISTER_BUS_MEM, cgpr_pkg::CORE_SPECIAL_REGISTER_COMPATIBILITY_CONFIG, cgpr_pkg::CORE_SPECIAL_REGISTER_MEM_INT,
             cgpr_pkg::CORE_SPECIAL_REGISTER_PHYS_MEM, cgpr_pkg::CORE_SPECIAL_REGISTER_SYS_MEM};
    repeat (5) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      mm[0][i] = '0;
      mm[1][i] = '0;
      cr(cgpr_pkg::DATA_BASE + 16'(4 * i), 32'h0);
      cr(cgpr_pkg::ADDR_BASE + 16'(4 * i), 32'h0);
    end
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk_sys_in);
      ctx_upper_in <= i[0];
      #1;
      chk({ctx_data_mask_out, ctx_addr_mask_out}, i ? 32'hff00fc00 : 32'h00ff00fc);
    end
    gw(1, 1'b1, 1'b0, 4'h0, 64'h5a5a_a5a5);
    gr(1, 1'b0, 4'hf);
    repeat (80)
    begin
      r = $random(seed);
      gw(r[0], r[1] & r[2], r[3], r[7:4], {$random(seed), $random(seed)});
      gr(r[8], r[9], r[13:10]);
      chk({stack_ptr_out, return_addr_out}, {mm[1][10], mm[1][11]});
    end
    // Call link must beat a same-cycle pipeline write to the same register
    r = $random(seed);
    @(posedge clk_sys_in);
    link_en_in   <= 1'b1;
    link_addr_in <= r;
    addr_wr_in   <= '{1'b1, 1'b0, 1'b0, 4'hb, 64'h0};
    @(posedge clk_sys_in);
    link_en_in    <= 1'b0;
    addr_wr_in.en <= 1'b0;
    #1;
    mm[1][11] = r;
    chk(return_addr_out, r);
    for (i = 0; i < 8; i++)
    begin
      r = $random(seed);
      cw(cgpr_pkg::DATA_BASE + 16'(4 * (2 * i + 1)), r, 1'b0);
      mm[0][2 * i + 1] = r;
      gr(0, 1'b0, 4'(2 * i));
      pv[i] = $random(seed);
      cw(prot[i], pv[i], 1'b0);
      cr(prot[i], pv[i]);
    end
    @(posedge clk_sys_in);
    end_req <= 1'b1;
    for (i = 0; i < 20 && init_done !== 1'b1; i++)
      @(posedge clk_sys_in);
    if (init_done !== 1'b1)
    begin
      miscompares++;
      results();
    end
    repeat (4) @(posedge clk_sys_in);
    for (i = 0; i < 8; i++)
    begin
      cw(prot[i], ~pv[i], 1'b1);
      cr(prot[i], pv[i]);
    end
    cw(cgpr_pkg::DATA_BASE + 16'h8, 32'hc3c3_3c3c, 1'b0);
    cr(cgpr_pkg::DATA_BASE + 16'h8, 32'hc3c3_3c3c);
    results();
  end
endmodule
`default_nettype wire
